/* File: src/duc_pkg.sv */
// shared constants and types for the baseband fifo and fm front end
package duc_pkg;
  // ****************************************
  // host port geometry
  // ****************************************
  localparam int DW = 16;
  localparam int AW = 10;
  localparam logic [9:0] CW_IDATA = 10'h000;
  localparam logic [9:0] CW_QDATA = 10'h001;
  localparam logic [9:0] CW_MODE  = 10'h010;
  localparam logic [9:0] CW_FIFO  = 10'h012;
  localparam logic [9:0] CW_STAT  = 10'h014;
  // ****************************************
  // control fields
  // ****************************************
  localparam int MODE_LSB = 0;
  localparam int HDLY_BIT = 2;
  localparam int ISEL_LSB = 3;
  localparam int THR_LSB  = 0;
  localparam logic [1:0] MODE_QUAD = 2'h0;
  localparam logic [1:0] MODE_FMBL = 2'h1;
  localparam logic [1:0] MODE_FMPS = 2'h2;
  localparam logic [1:0] MODE_RST  = 2'h0;
  localparam logic [1:0] ISEL_RST  = 2'h0;
  localparam logic [2:0] THR_RST   = 3'h0;
  // ****************************************
  // storage and timing
  // ****************************************
  localparam int FIFO_DEPTH = 7;
  localparam int WR_GAP_CYC = 4;
  localparam int HDLY_MAX   = 8;
  localparam int NCO_W      = 16;
  typedef struct packed {
    logic signed [15:0] i;
    logic signed [15:0] q;
  } duc_smp_t;
endpackage

/* File: src/duc_fifo_fm.sv */
// baseband i/q sample fifos, mode routing and fm modulator front end
`timescale 1ns/100ps
module duc_fifo_fm
  import duc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  // host bus
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] data_i,
  output logic      [DW-1:0] data_o,
  output logic               data_oe_o,
  input  wire logic          wr_n_i,
  input  wire logic          rd_n_i,
  input  wire logic          ce_n_i,
  // fifo status
  input  wire logic [NCO_W-1:0] samp_step_i,
  output logic               depth_request_out_o,
  output logic               sample_take_strobe_o,
  output logic               fifo_err_o,
  // to shaping filter
  output logic               flt_valid_o,
  input  wire logic          flt_ready_i,
  output duc_smp_t           flt_data_o,
  // from shaping filter
  input  wire logic          flt_out_valid_i,
  input  wire duc_smp_t      flt_out_i,
  // to scaling stage
  output logic               scl_valid_o,
  output duc_smp_t           scl_data_o,
  // cascade summer
  input  wire logic [DW-1:0] ups_i,
  input  wire logic [DW-1:0] cas_i,
  input  wire logic          cas_zero_i,
  output logic [DW-1:0]      sum_o
);
  // ****************************************
  // helpers
  // ****************************************
  // parabolic sine, phase as signed half turns
  function automatic logic signed [15:0] sin_apx(input logic [15:0] ph);
    logic signed [16:0] x;
    logic signed [16:0] m;
    logic signed [33:0] p;
    x = {ph[15], ph};
    m = 17'sh08000 - (x[16] ? -x : x);
    p = x * m;
    if (p >>> 13 > 34'sh07FFF) sin_apx = 16'sh7FFF;
    else sin_apx = p[28:13];
  endfunction
  function automatic duc_smp_t fm_out(input logic [15:0] ph);
    fm_out.i = sin_apx(ph + 16'h4000);
    fm_out.q = sin_apx(ph);
  endfunction
  // ****************************************
  // host write decode
  // ****************************************
  logic       wr_n_ff;
  logic       wr_stb;
  logic [1:0] push;
  logic [1:0] pop;
  logic [1:0] full;
  logic       err;
  logic [1:0] mode_ff;
  logic       hdly_ff;
  logic [1:0] isel_ff;
  logic [2:0] thr_ff;
  assign wr_stb  = wr_n_i & ~wr_n_ff & ~ce_n_i;
  assign push[0] = wr_stb && addr_i == CW_IDATA;
  assign push[1] = wr_stb && addr_i == CW_QDATA;
  // a write into a full fifo would corrupt air data, so flush instead
  assign err = |(push & full);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) wr_n_ff <= 1'b1;
    else wr_n_ff <= wr_n_i;
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_ff <= MODE_RST;
      hdly_ff <= 1'b0;
      isel_ff <= ISEL_RST;
      thr_ff  <= THR_RST;
    end else if (wr_stb && addr_i == CW_MODE) begin
      mode_ff <= data_i[MODE_LSB +: 2];
      hdly_ff <= data_i[HDLY_BIT];
      isel_ff <= data_i[ISEL_LSB +: 2];
    end else if (wr_stb && addr_i == CW_FIFO) begin
      thr_ff <= data_i[THR_LSB +: 3];
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) fifo_err_o <= 1'b0;
    else fifo_err_o <= err;
  end
  // ****************************************
  // sample fifos
  // ****************************************
  logic [15:0] mem  [2][DEPTH];
  logic [2:0]  cnt  [2];
  logic [2:0]  wp   [2];
  logic [2:0]  rp   [2];
  logic [15:0] head [2];
  for (genvar c = 0; c < 2; c++) begin : g_fifo
    assign full[c] = cnt[c] == 3'(DEPTH);
    assign head[c] = cnt[c] != 3'h0 ? mem[c][rp[c]] : 16'h0000;
    always_ff @(posedge clk_i) begin
      if (push[c] && !full[c]) mem[c][wp[c]] <= data_i;
    end
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        cnt[c] <= 3'h0;
        wp[c]  <= 3'h0;
        rp[c]  <= 3'h0;
      end else if (err) begin
        cnt[c] <= 3'h0;
        wp[c]  <= 3'h0;
        rp[c]  <= 3'h0;
      end else begin
        if (push[c]) wp[c] <= wp[c] == 3'(DEPTH - 1) ? 3'h0 : wp[c] + 3'h1;
        if (pop[c] && cnt[c] != 3'h0)
          rp[c] <= rp[c] == 3'(DEPTH - 1) ? 3'h0 : rp[c] + 3'h1;
        case ({push[c], pop[c] && cnt[c] != 3'h0})
          2'b10:   cnt[c] <= cnt[c] + 3'h1;
          2'b01:   cnt[c] <= cnt[c] - 3'h1;
          default: cnt[c] <= cnt[c];
        endcase
      end
    end
  end
  // ****************************************
  // depth request and sample strobe
  // ****************************************
  logic [NCO_W-1:0] snco_ff;
  logic             pend_ff;
  logic             take;
  logic             in_rdy;
  logic             nxt_msb;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) depth_request_out_o <= 1'b0;
    else depth_request_out_o <= cnt[0] <= thr_ff ||
                                (mode_ff == MODE_QUAD && cnt[1] <= thr_ff);
  end
  // msb of the rate accumulator is the strobe; its fall is the take
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) snco_ff <= '0;
    else if (err) snco_ff <= '0;
    else snco_ff <= snco_ff + samp_step_i;
  end
  assign sample_take_strobe_o = snco_ff[NCO_W-1];
  // set beats clear so a fall in the same cycle as a take is not lost
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) pend_ff <= 1'b0;
    else if (err) pend_ff <= 1'b0;
    else if (snco_ff[NCO_W-1] && !nxt_msb) pend_ff <= 1'b1;
    else if (take) pend_ff <= 1'b0;
  end
  assign nxt_msb = snco_ff[NCO_W-1] ^ (snco_ff[NCO_W-2:0] + samp_step_i[NCO_W-2:0]
                   >= {1'b1, {(NCO_W-1){1'b0}}}) ^ samp_step_i[NCO_W-1];
  assign take   = pend_ff & in_rdy;
  assign pop[0] = take;
  assign pop[1] = take && mode_ff == MODE_QUAD;
  // ****************************************
  // fm modulator phase accumulator
  // ****************************************
  logic [15:0] fm_ph_ff;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) fm_ph_ff <= 16'h0000;
    else if (err) fm_ph_ff <= 16'h0000;
    else if (take && mode_ff == MODE_FMBL) fm_ph_ff <= fm_ph_ff + head[0];
    else if (flt_out_valid_i && mode_ff == MODE_FMPS)
      fm_ph_ff <= fm_ph_ff + flt_out_i.i;
  end
  // ****************************************
  // two-entry buffer toward the shaping filter
  // ****************************************
  duc_smp_t nxt_in;
  duc_smp_t buf_mem [2];
  logic     buf_wp_ff;
  logic     buf_rp_ff;
  logic [1:0] buf_cnt_ff;
  always_comb begin
    case (mode_ff)
      MODE_QUAD: nxt_in = '{i: head[0], q: head[1]};
      MODE_FMBL: nxt_in = fm_out(fm_ph_ff + head[0]);
      MODE_FMPS: nxt_in = '{i: head[0], q: 16'sh0000};
      default:   nxt_in = '0;
    endcase
  end
  assign in_rdy      = buf_cnt_ff != 2'h2;
  assign flt_valid_o = buf_cnt_ff != 2'h0;
  assign flt_data_o  = buf_mem[buf_rp_ff];
  always_ff @(posedge clk_i) begin
    if (take) buf_mem[buf_wp_ff] <= nxt_in;
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      buf_wp_ff  <= 1'b0;
      buf_rp_ff  <= 1'b0;
      buf_cnt_ff <= 2'h0;
    end else if (err) begin
      buf_wp_ff  <= 1'b0;
      buf_rp_ff  <= 1'b0;
      buf_cnt_ff <= 2'h0;
    end else begin
      if (take) buf_wp_ff <= ~buf_wp_ff;
      if (flt_valid_o && flt_ready_i) buf_rp_ff <= ~buf_rp_ff;
      buf_cnt_ff <= buf_cnt_ff + 2'(take) - 2'(flt_valid_o && flt_ready_i);
    end
  end
  // ****************************************
  // half-sample delay and scaling mux
  // ****************************************
  logic [15:0] dly_ff [HDLY_MAX];
  logic [15:0] dly_i;
  always_ff @(posedge clk_i) begin
    if (flt_out_valid_i) begin
      dly_ff[0] <= flt_out_i.i;
      for (int k = 1; k < HDLY_MAX; k++) dly_ff[k] <= dly_ff[k-1];
    end
  end
  // half of 4, 8 or 16 filter outputs is one half input sample
  assign dly_i = dly_ff[3'((4'h2 << isel_ff) - 4'h1)];
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_valid_o <= 1'b0;
      scl_data_o  <= '0;
    end else begin
      scl_valid_o <= flt_out_valid_i;
      if (flt_out_valid_i) begin
        if (mode_ff == MODE_FMPS) scl_data_o <= fm_out(fm_ph_ff + flt_out_i.i);
        else if (mode_ff == MODE_QUAD && hdly_ff) scl_data_o <= '{i: dly_i, q: flt_out_i.q};
        else scl_data_o <= flt_out_i;
      end
    end
  end
  // ****************************************
  // cascade summer
  // ****************************************
  logic [DW-1:0] cas_eff;
  logic [DW:0]   sum_w;
  assign cas_eff = cas_zero_i ? '0 : cas_i;
  assign sum_w   = {ups_i[DW-1], ups_i} + {cas_eff[DW-1], cas_eff};
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) sum_o <= '0;
    else if (sum_w[DW] != sum_w[DW-1]) sum_o <= {sum_w[DW], {(DW-1){~sum_w[DW]}}};
    else sum_o <= sum_w[DW-1:0];
  end
  // ****************************************
  // read-back
  // ****************************************
  assign data_oe_o = ~rd_n_i & ~ce_n_i;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) data_o <= '0;
    else begin
      case (addr_i)
        CW_MODE: data_o <= {11'h000, isel_ff, hdly_ff, mode_ff};
        CW_FIFO: data_o <= {13'h0000, thr_ff};
        CW_STAT: data_o <= {8'h00, fifo_err_o, cnt[1], 1'b0, cnt[0]};
        default: data_o <= '0;
      endcase
    end
  end
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_full_write;
    full[0] && push[0];
  endsequence
  a_push_count: assert property (push[0] && !full[0] && !pop[0] && !err
    |=> cnt[0] == $past(cnt[0]) + 3'h1) else $error("push did not count");
  a_pop_count: assert property (pop[0] && cnt[0] != 3'h0 && !push[0] && !err
    |=> cnt[0] == $past(cnt[0]) - 3'h1) else $error("pop did not count");
  a_depth_bound: assert property (cnt[0] == 3'(DEPTH)
    |=> cnt[0] >= 3'(DEPTH - 1) || fifo_err_o) else $error("fifo over depth");
  a_full_flush: assert property (s_full_write |=> cnt[0] == 3'h0 && fifo_err_o)
    else $error("full write not flushed");
  a_full_hold: assert property (full[0] && !pop[0] && !err |=> full[0])
    else $error("full fifo drained without request");
  a_empty_zero: assert property (take && cnt[0] == 3'h0 && cnt[1] == 3'h0 && !err
    && mode_ff == MODE_QUAD && buf_cnt_ff == 2'h0 |=> flt_valid_o && flt_data_o == '0)
    else $error("empty fifo gave nonzero");
  a_dreq_set: assert property (cnt[0] <= thr_ff |=> depth_request_out_o)
    else $error("depth request missing");
  a_dreq_clr: assert property (cnt[0] > thr_ff && cnt[1] > thr_ff
    |=> !depth_request_out_o) else $error("depth request stuck");
  a_take_fall: assert property ($fell(sample_take_strobe_o) && !$past(err)
    |-> pend_ff) else $error("strobe fall not taken");
  a_mode_write: assert property (wr_stb && addr_i == CW_MODE
    |=> mode_ff == $past(data_i[1:0])) else $error("mode not latched");
  a_sum_sat: assert property (!ups_i[DW-1] && !cas_eff[DW-1]
    |=> !sum_o[DW-1]) else $error("sum wrapped");
endmodule

/* File: verif/duc_host_model.sv */
// host processor model driving the control and sample bus
`timescale 1ns/100ps
module duc_host_model
  import duc_pkg::*;
(
  // clock
  input  wire logic          clk_i,
  // host bus
  output logic [AW-1:0]      addr_o,
  output logic [DW-1:0]      data_o,
  output logic               wr_n_o,
  output logic               rd_n_o,
  output logic               ce_n_o,
  input  wire logic [DW-1:0] rdata_i,
  input  wire logic          oe_i
);
  initial begin
    addr_o = '0;
    data_o = '0;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    ce_n_o = 1'b1;
  end
  // ****************************************
  // bus cycles, moved on falling edges only
  // ****************************************
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(negedge clk_i);
    ce_n_o = 1'b0;
    wr_n_o = 1'b0;
    addr_o = a;
    data_o = d;
    @(negedge clk_i);
    wr_n_o = 1'b1;
    @(negedge clk_i);
    ce_n_o = 1'b1;
    // released bus must not keep the last word
    data_o = ~d;
    repeat (WR_GAP_CYC) @(negedge clk_i);
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(negedge clk_i);
    ce_n_o = 1'b0;
    rd_n_o = 1'b0;
    addr_o = a;
    repeat (2) @(negedge clk_i);
    d = oe_i ? rdata_i : ~rdata_i;
    ce_n_o = 1'b1;
    rd_n_o = 1'b1;
  endtask
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the sample fifos and front end
`timescale 1ns/100ps
module testbench;
  import duc_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic            clk_i     = 1'b0;
  logic            sys_rst_i = 1'b1;
  logic            fr        = 1'b0;
  logic            fov       = 1'b0;
  logic            cz        = 1'b0;
  logic            stall     = 1'b0;
  logic [NCO_W-1:0] step     = '0;
  logic [DW-1:0]   ups       = '0;
  logic [DW-1:0]   cas       = '0;
  duc_smp_t        fout      = '0;
  logic [AW-1:0]   addr;
  logic [DW-1:0]   wdata, rdata, sum, rv;
  logic            wr_n, rd_n, ce_n, oe, dreq, strobe, strobe_d, ferr, fv, sv;
  duc_smp_t        fdata, sdata, s, tf[3];
  duc_smp_t        exp_q[$];
  int              errors, cmp_count, cycles, err_seen, falls;
  always #5 clk_i = ~clk_i;
  duc_host_model host (.clk_i(clk_i), .addr_o(addr), .data_o(wdata), .wr_n_o(wr_n),
    .rd_n_o(rd_n), .ce_n_o(ce_n), .rdata_i(rdata), .oe_i(oe));
  duc_fifo_fm dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .data_i(wdata),
    .data_o(rdata), .data_oe_o(oe), .wr_n_i(wr_n), .rd_n_i(rd_n), .ce_n_i(ce_n),
    .samp_step_i(step), .depth_request_out_o(dreq), .sample_take_strobe_o(strobe),
    .fifo_err_o(ferr), .flt_valid_o(fv), .flt_ready_i(fr), .flt_data_o(fdata),
    .flt_out_valid_i(fov), .flt_out_i(fout), .scl_valid_o(sv), .scl_data_o(sdata),
    .ups_i(ups), .cas_i(cas), .cas_zero_i(cz), .sum_o(sum));
  // ****************************************
  // compare and verdict
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ****************************************
  // output watcher, filter side stalls at random
  // ****************************************
  always @(negedge clk_i) fr <= stall ? 1'b0 : 1'($urandom_range(1, 0));
  // status pins are looked at mid-cycle, where they have settled
  always @(negedge clk_i) begin
    if (ferr === 1'b1) err_seen++;
    if (strobe_d === 1'b1 && strobe === 1'b0) falls++;
    strobe_d <= strobe;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      errors++;
      close_out();
    end
    // an empty queue means the fifo ran dry and zeros are due
    if (sys_rst_i === 1'b0 && fv === 1'b1 && fr === 1'b1)
      check(fdata, exp_q.size() ? exp_q.pop_front() : 32'h0);
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [15:0] tu[4] = '{16'h7FFF, 16'h8000, 16'h1234, 16'h7FFF};
    logic [15:0] tc[4] = '{16'h0001, 16'hFFFF, 16'h0100, 16'h7FFF};
    logic [15:0] ts[4] = '{16'h7FFF, 16'h8000, 16'h1334, 16'h7FFF};
    void'($urandom(77059));
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check(dreq, 1);
    for (int m = 2; m >= 0; m--) begin
      host.wr(CW_MODE, 16'(m));
      host.rd(CW_MODE, rv);
      check(rv[1:0], m);
    end
    host.wr(CW_FIFO, 16'h0003);
    for (int i = 0; i < 7; i++) begin
      host.wr(CW_IDATA, 16'($urandom));
      host.wr(CW_QDATA, 16'($urandom));
      check(dreq, i < 3);
    end
    repeat (20) @(negedge clk_i);
    host.rd(CW_STAT, rv);
    check(rv[6:0], 7'h77);
    host.wr(CW_IDATA, 16'h5A5A);
    check(err_seen, 1);
    host.rd(CW_STAT, rv);
    check(rv[6:0], 7'h00);
    for (int i = 0; i < 5; i++) begin
      s = duc_smp_t'($urandom);
      host.wr(CW_IDATA, s.i);
      host.wr(CW_QDATA, s.q);
      exp_q.push_back(s);
    end
    stall = 1'b1;
    falls = 0;
    step = 16'h2000;
    repeat (40) @(negedge clk_i);
    check(fv, 1);
    stall = 1'b0;
    repeat (80) @(negedge clk_i);
    step = '0;
    repeat (40) @(negedge clk_i);
    check(falls, 15);
    check(exp_q.size(), 0);
    host.rd(CW_STAT, rv);
    check(rv[6:0], 7'h00);
    fout = duc_smp_t'($urandom);
    fov = 1'b1;
    @(negedge clk_i);
    fov = 1'b0;
    check(sv, 1);
    check(sdata, fout);
    host.wr(CW_MODE, 16'h0004);
    for (int k = 0; k < 3; k++) begin
      tf[k] = duc_smp_t'($urandom);
      fout = tf[k];
      fov = 1'b1;
      @(negedge clk_i);
    end
    fov = 1'b0;
    // two outputs at interpolation 4 are half an input sample
    check(sdata, {tf[0].i, tf[2].q});
    host.wr(CW_MODE, {14'h0000, MODE_FMBL});
    host.wr(CW_IDATA, 16'h4000);
    // a quarter-turn step lands at cos 0, sin full scale
    exp_q.push_back(duc_smp_t'(32'h00007FFF));
    step = 16'h2000;
    repeat (8) @(negedge clk_i);
    step = '0;
    repeat (20) @(negedge clk_i);
    check(exp_q.size(), 0);
    host.wr(CW_MODE, {14'h0000, MODE_FMPS});
    // zero shaped input has no slew and keeps the quarter-turn phase
    fout = duc_smp_t'(32'h00001234);
    fov = 1'b1;
    @(negedge clk_i);
    fov = 1'b0;
    check(sv, 1);
    check(sdata, 32'h00007FFF);
    for (int k = 0; k < 4; k++) begin
      ups = tu[k];
      cas = tc[k];
      cz = (k == 3);
      @(negedge clk_i);
      check(sum, ts[k]);
    end
    close_out();
  end
endmodule
